// ---- async_host_port_with_reset_bench.sv ----
/* self-checking bench for the host port; host side is host_cpu_model.
   assumes a 50 ns clock and inputs changed 1 ns after rising edges. */
`timescale 1ns/1ps
module async_host_port_with_reset_bench;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        device_rst_n = 1'b1;
	logic        local_output_reset_state_sel = 1'b1;
	logic        backplane_output_reset_state_sel = 1'b0;
	logic        output_drive_enable = 1'b0;
	logic [15:0] local_stream_data = 16'h3c5a;
	logic [31:0] backplane_stream_data = 32'h0ff01234;
	logic        port_select_n, data_strobe_n, read_not_write, host_data_oe;
	logic [14:0] host_address_bus;
	logic [15:0] host_data_in, host_data_out, local_serial_out, local_serial_oe;
	logic [31:0] backplane_serial_out, backplane_serial_oe;
	logic [1:0]  local_ext_buffer_enable;
	logic [3:0]  backplane_ext_buffer_enable;
	logic        transfer_ack_n, transfer_ack_oe, in_reset;
	int          n_mismatch = 0;
	int          checks = 0;
	always #25 sys_clk = ~sys_clk;
	host_port dut (.sys_clk, .rst, .device_rst_n, .port_select_n, .data_strobe_n,
		.read_not_write, .host_address_bus, .host_data_in, .host_data_out, .host_data_oe,
		.transfer_ack_n, .transfer_ack_oe, .local_output_reset_state_sel,
		.backplane_output_reset_state_sel, .output_drive_enable, .local_stream_data,
		.backplane_stream_data, .local_serial_out, .local_serial_oe, .backplane_serial_out,
		.backplane_serial_oe, .local_ext_buffer_enable, .backplane_ext_buffer_enable, .in_reset);
	host_cpu_model host (.sys_clk, .host_data_out, .host_data_oe, .transfer_ack_oe,
		.port_select_n, .data_strobe_n, .read_not_write, .host_address_bus, .host_data_in);
	//////////////////////////////////////////////////////////////////////
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_run;
		for (int n = 0; n < 10 && in_reset !== 1'b0; n++) @(posedge sys_clk) #1;
		cmp("in_reset", 0, in_reset);
	endtask
	//////////////////////////////////////////////////////////////////////
	task automatic t_refused;
		int a;
		host.hold_pins(1'b1, 1'b0, a);
		cmp("acks select high", 0, a);
		host.hold_pins(1'b0, 1'b1, a);
		cmp("acks strobe high", 0, a);
		$display("done refused");
	endtask
	task automatic t_write_read;
		logic [15:0] rd;
		bit ok;
		// index 7 through the top address: only the low bits select
		for (int i = 0; i < 8; i++) begin
			host.access(1'b0, (i == 7) ? 15'h7fff : 15'(i), 16'ha5a5 ^ (16'h0001 << i), rd, ok);
			cmp("write ack", 1, ok);
		end
		cmp("ack level", 0, transfer_ack_n);
		for (int i = 0; i < 8; i++) begin
			host.access(1'b1, 15'(i), 16'h0000, rd, ok);
			cmp("read ack", 1, ok);
			cmp("read data", 16'ha5a5 ^ (16'h0001 << i), rd);
		end
		$display("done write_read");
	endtask
	task automatic t_device_reset;
		logic [15:0] rd;
		bit ok;
		for (int k = 0; k < 2; k++) begin
			host.access(1'b0, 15'h0002, 16'hbeef, rd, ok);
			@(posedge sys_clk);
			#1;
			cmp("enables before reset", 2'h3, local_ext_buffer_enable);
			local_output_reset_state_sel = k[0];
			backplane_output_reset_state_sel = ~k[0];
			device_rst_n = 1'b0;
			#1;
			cmp("local enables", 0, local_ext_buffer_enable);
			cmp("back enables", 0, backplane_ext_buffer_enable);
			cmp("local out", 16'hffff, local_serial_out);
			repeat (3) @(posedge sys_clk);
			#1;
			cmp("local oe", {16{k[0]}}, local_serial_oe);
			cmp("back oe", {32{~k[0]}}, backplane_serial_oe);
			cmp("back out", 32'hffffffff, backplane_serial_out);
			device_rst_n = 1'b1;
			@(posedge sys_clk) #1;
			cmp("in_reset held", 1, in_reset);
			wait_run();
			host.access(1'b1, 15'h0002, 16'h0000, rd, ok);
			cmp("cleared reg", 16'h0000, rd);
		end
		// synchronous reset pulse in mid-run must clear the registers too
		host.access(1'b0, 15'h0002, 16'hbeef, rd, ok);
		@(posedge sys_clk);
		#1;
		rst = 1'b1;
		@(posedge sys_clk);
		#1;
		rst = 1'b0;
		wait_run();
		host.access(1'b1, 15'h0002, 16'h0000, rd, ok);
		cmp("cleared by rst", 16'h0000, rd);
		$display("done device_reset");
	endtask
	task automatic t_stream;
		@(posedge sys_clk);
		#1;
		output_drive_enable = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		cmp("local stream", local_stream_data, local_serial_out);
		cmp("back stream", backplane_stream_data, backplane_serial_out);
		cmp("local oe on", 16'hffff, local_serial_oe);
		cmp("back oe on", 32'hffffffff, backplane_serial_oe);
		cmp("local enables on", 2'h3, local_ext_buffer_enable);
		cmp("back enables on", 4'hf, backplane_ext_buffer_enable);
		$display("done stream");
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		wait_run();
		t_refused();
		t_write_read();
		t_stream();
		t_device_reset();
		give_verdict();
	end
endmodule

// ---- host_cpu_model.sv ----
/* host processor model: strobed accesses with ack handshake, bus resolution.
   assumes the port samples on rising edges of sys_clk. */
`timescale 1ns/1ps
module host_cpu_model (
	input  wire logic        sys_clk,          // port clock
	input  wire logic [15:0] host_data_out,    // device read data
	input  wire logic        host_data_oe,     // device drives bus
	input  wire logic        transfer_ack_oe,  // ack pulled low
	output logic             port_select_n,    // select
	output logic             data_strobe_n,    // strobe
	output logic             read_not_write,   // direction
	output logic [14:0]      host_address_bus, // address
	output logic [15:0]      host_data_in      // resolved bus
);
	logic        drive_q = 1'b0;
	logic [15:0] wdata_q = 16'h0000;
	logic [15:0] last_q  = 16'h0000;
	// a floating bus shows the inverse of its last level, never a stale copy
	assign host_data_in = host_data_oe ? host_data_out : (drive_q ? wdata_q : ~last_q);
	always @(posedge sys_clk) last_q <= host_data_in;
	initial begin
		port_select_n = 1'b1;
		data_strobe_n = 1'b1;
		read_not_write = 1'b1;
		host_address_bus = 15'h0000;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic access(input logic rnw, input logic [14:0] addr, input logic [15:0] wd,
		output logic [15:0] rd, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge sys_clk);
		#1;
		read_not_write = rnw;
		host_address_bus = addr;
		wdata_q = wd;
		drive_q = ~rnw;
		port_select_n = 1'b0;
		data_strobe_n = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge sys_clk);
			#1;
			ok = (transfer_ack_oe === 1'b1);
		end
		rd = host_data_in;
		port_select_n = 1'b1;
		data_strobe_n = 1'b1;
		drive_q = 1'b0;
		for (n = 0; n < 20 && transfer_ack_oe !== 1'b0; n++) @(posedge sys_clk) #1;
		ok = ok && (transfer_ack_oe === 1'b0);
		repeat (host_port_pkg::GAP_CYC) @(posedge sys_clk);
	endtask
	// strobe and select held apart: count cycles that were acknowledged
	task automatic hold_pins(input logic sel_n, input logic ds_n, output int acks);
		acks = 0;
		@(posedge sys_clk);
		#1;
		port_select_n = sel_n;
		data_strobe_n = ds_n;
		repeat (6) begin
			@(posedge sys_clk);
			#1;
			if (transfer_ack_oe !== 1'b0) acks++;
		end
		port_select_n = 1'b1;
		data_strobe_n = 1'b1;
	endtask
endmodule

// ---- host_port.sv ----
/*
 * host port top: strobed host access to a small register array, acknowledge
 * handshake, reset synchroniser and reset-safe serial and buffer-enable outputs.
 * assumes host pins synchronous to sys_clk and an external pull-up on ack.
 */
`timescale 1ns/1ps
module host_port #(
	parameter int DATA_W = host_port_pkg::DATA_W,
	parameter int ADDR_W = host_port_pkg::ADDR_W
) (
	input  wire logic                            sys_clk,       // 20 MHz clock
	input  wire logic                            rst,           // sync reset, active high
	input  wire logic                            device_rst_n,  // device reset pin
	input  wire logic                            port_select_n, // host select
	input  wire logic                            data_strobe_n, // host strobe
	input  wire logic                            read_not_write,// 1 read, 0 write
	input  wire logic [ADDR_W-1:0]               host_address_bus, // address
	input  wire logic [DATA_W-1:0]               host_data_in,  // bus level seen
	output logic      [DATA_W-1:0]               host_data_out, // read data
	output logic                                 host_data_oe,  // drive bus
	output logic                                 transfer_ack_n,   // ack level
	output logic                                 transfer_ack_oe,  // drive ack
	input  wire logic                            local_output_reset_state_sel, // 1 high
	input  wire logic                            backplane_output_reset_state_sel,
	input  wire logic                            output_drive_enable, // outputs on
	input  wire logic [host_port_pkg::LOCAL_N-1:0] local_stream_data, // from switch
	input  wire logic [host_port_pkg::BACK_N-1:0]  backplane_stream_data,
	output logic      [host_port_pkg::LOCAL_N-1:0] local_serial_out,    // level
	output logic      [host_port_pkg::LOCAL_N-1:0] local_serial_oe,     // drive
	output logic      [host_port_pkg::BACK_N-1:0]  backplane_serial_out,
	output logic      [host_port_pkg::BACK_N-1:0]  backplane_serial_oe,
	output logic      [host_port_pkg::LOCAL_EN_N-1:0] local_ext_buffer_enable,
	output logic      [host_port_pkg::BACK_EN_N-1:0]  backplane_ext_buffer_enable,
	output logic                                 in_reset       // synced reset state
);
	localparam int LN = host_port_pkg::LOCAL_N;
	localparam int BN = host_port_pkg::BACK_N;

	////////////////////////////////////////////////////////////////////////////
	// reset: asserted at once by the pin and at the next clock edge by rst, released through two flops
	logic rst_meta_q;
	logic rst_sync_q;
	wire  rst_any = rst | ~device_rst_n;
	always_ff @(posedge sys_clk or negedge device_rst_n) begin
		if (!device_rst_n) begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= 1'b1;
		end else if (rst) begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= 1'b1;
		end else begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// access decode
	wire access = ~port_select_n & ~data_strobe_n;
	wire [host_port_pkg::REG_IDX_W-1:0] reg_idx =
		host_address_bus[host_port_pkg::REG_IDX_W-1:0];

	host_port_pkg::port_state_type state_q;
	host_port_pkg::port_state_type state_d;
	logic [DATA_W-1:0] regs_q [host_port_pkg::REG_DEPTH];
	logic [DATA_W-1:0] rdata_q;
	logic              ack_q;
	logic              drive_q;
	logic [1:0]        gap_q;
	logic [15:0]       access_cnt_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			host_port_pkg::ST_IDLE: begin
				if (access) begin
					state_d = host_port_pkg::ST_ACK;
				end
			end
			host_port_pkg::ST_ACK: begin
				if (!access) begin
					state_d = host_port_pkg::ST_IDLE;
				end else begin
					state_d = host_port_pkg::ST_HOLD;
				end
			end
			host_port_pkg::ST_HOLD: begin
				if (!access) begin
					state_d = host_port_pkg::ST_IDLE;
				end
			end
			default: state_d = host_port_pkg::ST_IDLE;
		endcase
	end

	wire take_write = (state_q == host_port_pkg::ST_IDLE) & access & ~read_not_write;

	always_ff @(posedge sys_clk or negedge device_rst_n) begin
		if (!device_rst_n) begin
			state_q      <= host_port_pkg::ST_IDLE;
			ack_q        <= 1'b0;
			drive_q      <= 1'b0;
			rdata_q      <= '0;
			access_cnt_q <= 16'h0000;
		end else if (rst_sync_q || rst) begin
			state_q      <= host_port_pkg::ST_IDLE;
			ack_q        <= 1'b0;
			drive_q      <= 1'b0;
			rdata_q      <= '0;
			access_cnt_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			ack_q   <= (state_d != host_port_pkg::ST_IDLE);
			drive_q <= (state_d != host_port_pkg::ST_IDLE) & read_not_write;
			if ((state_q == host_port_pkg::ST_IDLE) && access) begin
				rdata_q      <= regs_q[reg_idx];
				access_cnt_q <= access_cnt_q + 16'h0001;
			end
		end
	end

	// register array: cleared by reset, written on accepted write strobes
	generate
		for (genvar i = 0; i < host_port_pkg::REG_DEPTH; i++) begin : g_reg
			always_ff @(posedge sys_clk or negedge device_rst_n) begin
				if (!device_rst_n) begin
					regs_q[i] <= host_port_pkg::REG_RESET;
				end else if (rst_sync_q || rst) begin
					regs_q[i] <= host_port_pkg::REG_RESET;
				end else if (take_write && reg_idx == i) begin
					regs_q[i] <= host_data_in;
				end
			end
		end
	endgenerate

	// host gap tracker for the assertion below only
	always_ff @(posedge sys_clk) begin
		if (rst_any) begin
			gap_q <= 2'b00;
		end else if (ack_q && state_d == host_port_pkg::ST_IDLE) begin
			gap_q <= 2'b01;
		end else begin
			gap_q <= 2'b00;
		end
	end

	assign host_data_out   = rdata_q;
	assign host_data_oe    = drive_q;
	assign transfer_ack_n  = 1'b0;     // only ever pulls low; pull-up gives high
	assign transfer_ack_oe = ack_q;

	////////////////////////////////////////////////////////////////////////////
	// serial outputs and external buffer enables
	logic [LN-1:0] lso_q, loe_q;
	logic [BN-1:0] bso_q, boe_q;
	logic [host_port_pkg::LOCAL_EN_N-1:0] lbe_q;
	logic [host_port_pkg::BACK_EN_N-1:0]  bbe_q;
	wire  live = ~rst_sync_q & output_drive_enable;

	always_ff @(posedge sys_clk or negedge device_rst_n) begin
		if (!device_rst_n) begin
			lso_q <= '1;
			bso_q <= '1;
			lbe_q <= '0;
			bbe_q <= '0;
		end else begin
			lso_q <= live ? local_stream_data : '1;
			bso_q <= live ? backplane_stream_data : '1;
			lbe_q <= live ? '1 : '0;
			bbe_q <= live ? '1 : '0;
		end
	end

	// no async reset here: the reset state follows the select pins, which an
	// async branch cannot read; the pin reset sets rst_sync_q at once, so the
	// enables reach their reset state on the first clock edge of reset
	always_ff @(posedge sys_clk) begin
		loe_q <= live ? '1 : {LN{local_output_reset_state_sel}};
		boe_q <= live ? '1 : {BN{backplane_output_reset_state_sel}};
	end

	assign local_serial_out            = lso_q;
	assign local_serial_oe             = loe_q;
	assign backplane_serial_out        = bso_q;
	assign backplane_serial_oe         = boe_q;
	assign local_ext_buffer_enable     = lbe_q;
	assign backplane_ext_buffer_enable = bbe_q;
	assign in_reset                    = rst_sync_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence strobe_begin;
		$fell(port_select_n | data_strobe_n);
	endsequence

	ack_follows_access_a: assert property (@(posedge sys_clk) disable iff (rst_any)
		strobe_begin |=> transfer_ack_oe)
		else $error("ack not driven after access");
	ack_release_a: assert property (@(posedge sys_clk) disable iff (rst_any)
		(port_select_n | data_strobe_n) |=> !transfer_ack_oe)
		else $error("ack not released");
	no_access_idle_a: assert property (@(posedge sys_clk) disable iff (rst_any)
		port_select_n |=> !host_data_oe)
		else $error("bus driven while deselected");
	read_drives_a: assert property (@(posedge sys_clk) disable iff (rst_any)
		(access && read_not_write) |=> host_data_oe)
		else $error("read did not drive bus");
	write_no_drive_a: assert property (@(posedge sys_clk) disable iff (rst_any)
		(access && !read_not_write) |=> !host_data_oe)
		else $error("write drove bus");
	write_stores_a: assert property (@(posedge sys_clk) disable iff (rst_any)
		take_write |=> regs_q[$past(reg_idx)] == $past(host_data_in))
		else $error("write lost");
	reset_enables_a: assert property (@(posedge sys_clk)
		rst_sync_q |=> (local_ext_buffer_enable == '0 && backplane_ext_buffer_enable == '0))
		else $error("buffer enable high in reset");
	reset_serial_a: assert property (@(posedge sys_clk)
		rst_sync_q |=> (local_serial_out == '1 && backplane_serial_out == '1))
		else $error("serial output low in reset");
	reset_release_a: assert property (@(posedge sys_clk)
		($rose(device_rst_n) && !rst) |-> rst_sync_q ##1 rst_sync_q)
		else $error("reset released too early");
	gap_check_a: assert property (@(posedge sys_clk) disable iff (rst_any)
		(gap_q == 2'b01) |-> !transfer_ack_oe)
		else $error("ack reasserted inside gap");
	clear_all_a: assert property (@(posedge sys_clk)
		rst |=> (access_cnt_q == 16'h0000 && regs_q[0] == host_port_pkg::REG_RESET))
		else $error("reset did not clear");
endmodule

// ---- host_port_pkg.sv ----
/*
 * constants for the asynchronous host port with device reset.
 * assumes a single 20 MHz clock; host pins are already synchronous to it.
 */
package host_port_pkg;
	localparam int DATA_W        = 16;
	localparam int ADDR_W        = 15;
	localparam int LOCAL_N       = 16;
	localparam int BACK_N        = 32;
	localparam int LOCAL_EN_N    = 2;
	localparam int BACK_EN_N     = 4;
	localparam int CLK_PERIOD_NS = 50;
	localparam int GAP_NS        = 30;
	// least time, rounded up, at least one cycle
	localparam int GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REG_DEPTH     = 8;
	localparam int REG_IDX_W     = 3;
	localparam logic [15:0] REG_RESET = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACK  = 2'b01,
		ST_HOLD = 2'b10
	} port_state_type;
endpackage
